/* File: src/lisif_cap_if.sv */
/*
 lisif_cap_if: captured link edges and levels from the sampler to the formatter.
 Assumes: both ends sit on the same system clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface lisif_cap_if;
   logic rise;
   logic fall;
   logic [15:0] data;
   logic bnd;
   logic aux;
   modport src (output rise, output fall, output data, output bnd, output aux);
   modport dst (input rise, input fall, input data, input bnd, input aux);
endinterface
`default_nettype wire

/* File: src/lisif_capture.sv */
/*
 lisif_capture: synchronises the link clock, lanes and strobes into the system
 clock and marks the link clock edges.
 Assumes: system clock runs well above twice the link clock; lanes stable around edges.
*/
`timescale 1ns/1ns
`default_nettype none
module lisif_capture
   import lisif_pkg::*;
(
   // system
   input wire logic i_clk,
   input wire logic i_rst_n,
   // link pins
   input wire logic i_link_clk,
   input wire logic [15:0] i_data,
   input wire logic i_bnd,
   input wire logic i_aux,
   // to formatter
   lisif_cap_if.src cap
);
   // first stage feeds only the second stage
   logic [18:0] s1;
   logic [18:0] s2;
   logic clk_d;
   logic [18:0] next_s1;
   logic [18:0] next_s2;
   logic next_clk_d;

   always_comb begin
      next_s1 = {i_link_clk, i_bnd, i_aux, i_data};
      next_s2 = s1;
      next_clk_d = s2[18];
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s1 <= 19'h00000;
         s2 <= 19'h00000;
         clk_d <= 1'b0;
      end else begin
         s1 <= next_s1;
         s2 <= next_s2;
         clk_d <= next_clk_d;
      end
   end

   // lanes share the clock's latency, so each edge sees aligned data
   assign cap.rise = s2[18] & ~clk_d;
   assign cap.fall = ~s2[18] & clk_d;
   assign cap.bnd = s2[17];
   assign cap.aux = s2[16];
   assign cap.data = s2[15:0];
endmodule // lisif_capture
`default_nettype wire

/* File: src/lisif_pkg.sv */
/*
 lisif_pkg: constants shared by the lvds i/q sample input formatter.
 Assumes: the consumer imports the whole package.
*/
// Function
// - one width-select input picks word-wide or byte-wide input format.
// - width-select high means word-wide, one 16-bit word per clock edge.
// - width-select low means byte-wide, one byte per clock edge.
// - word mode uses all sixteen lanes; byte mode ignores upper eight lanes.
// - lanes are captured on both rising and falling data clock edges.
// - boundary or auxiliary strobe may reset write pointer, read pointer, or both.
// - in byte mode a selected strobe rise fixes which byte starts a sample.
// - strobe rises are detected only on rising data clock edges.
// - with parity on, boundary level at following falling edge is block parity.
// - block parity sampling works only while the parity enable input is one.
// - word order is I0, Q0, I1, Q1; lane 0 is lsb, lane 15 msb.
// - byte order is I high, I low, Q high, Q low, then next I high.
// - word mode only: register-write trigger aligns pointers when formatter field is 10 or 11.
// - register trigger also needs both pointer source fields equal to 1000.
// - each I word and Q word form one 32-bit sample written at write pointer.
// - rising edge of selected source returns the affected pointer to its reset position.
package lisif_pkg;
   localparam int LISIF_DATA_W = 16;
   localparam int LISIF_BYTE_W = 8;
   localparam int LISIF_SAMPLE_W = 32;
   localparam int LISIF_DEPTH = 8;
   localparam int LISIF_PTR_W = 3;
   localparam logic [2:0] LISIF_PTR_ONE = 3'h1;
   localparam logic [2:0] LISIF_WR_PTR_RESET = 3'h0;
   localparam logic [2:0] LISIF_RD_PTR_RESET = 3'h4;
   // pointer source field bit positions
   localparam int LISIF_SRC_AUX_BIT = 0;
   localparam int LISIF_SRC_BND_BIT = 1;
   localparam int LISIF_SRC_OSTR_BIT = 2;
   localparam int LISIF_SRC_REG_BIT = 3;
   localparam logic [3:0] LISIF_SRC_REG_TRIG = 4'h8;
   localparam logic [1:0] LISIF_FMT_REG_A = 2'h2;
   localparam logic [1:0] LISIF_FMT_REG_B = 2'h3;
   localparam logic LISIF_WIDTH_WORD = 1'b1;
   localparam logic [1:0] LISIF_SLOT_I_HI = 2'h0;
   localparam logic [1:0] LISIF_SLOT_I_LO = 2'h1;
   localparam logic [1:0] LISIF_SLOT_Q_HI = 2'h2;
   localparam logic [1:0] LISIF_SLOT_Q_LO = 2'h3;
   localparam int LISIF_SYNC_STAGES = 2;
endpackage

/* File: src/lisif_top.sv */
/*
 lisif_top: rebuilds 32-bit I/Q samples from the ddr lvds bus, aligns sample
 boundaries and fifo pointers on strobes, and samples block parity.
 Assumes: configuration inputs are static or from the system clock domain;
 i_sif_sync and i_read are one-cycle pulses on I_MCLK.
*/
`timescale 1ns/1ns
`default_nettype none
module lisif_top
   import lisif_pkg::*;
(
   // system
   input wire logic I_MCLK,
   input wire logic I_RST_N,
   // link pins
   input wire logic I_DDR_SOURCE_CLOCK,
   input wire logic [15:0] I_DATA,
   input wire logic I_BOUNDARY_STROBE,
   input wire logic I_AUX_STROBE,
   // configuration
   input wire logic I_WORD_WIDTH_SELECT,
   input wire logic I_PARITY_ENABLE,
   input wire logic [3:0] I_WR_PTR_SOURCE,
   input wire logic [3:0] I_RD_PTR_SOURCE,
   input wire logic [1:0] I_FORMATTER_SOURCE,
   input wire logic I_SIF_SYNC,
   // fifo read side
   input wire logic I_READ,
   output logic [31:0] O_READ_DATA,
   output logic O_READ_VALID,
   // status
   output logic [31:0] O_SAMPLE,
   output logic O_SAMPLE_VALID,
   output logic [2:0] O_WR_PTR,
   output logic [2:0] O_RD_PTR,
   output logic O_ALIGNED,
   output logic O_BLOCK_PARITY,
   output logic O_PARITY_VALID
);

   function automatic logic [2:0] lisif_inc(input logic [2:0] p);
      lisif_inc = p + LISIF_PTR_ONE;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   lisif_cap_if cap ();

   lisif_capture u_cap (
      .i_clk(I_MCLK),
      .i_rst_n(I_RST_N),
      .i_link_clk(I_DDR_SOURCE_CLOCK),
      .i_data(I_DATA),
      .i_bnd(I_BOUNDARY_STROBE),
      .i_aux(I_AUX_STROBE),
      .cap(cap.src)
   );

   ////////////////////////////////////////////////////////////////////////////
   // strobe edges and pointer reset sources
   logic bnd_q;
   logic aux_q;
   logic bnd_rise;
   logic aux_rise;
   logic wr_src_rise;
   logic rd_src_rise;
   logic reg_trig;
   logic wr_reset;
   logic rd_reset;
   logic word_mode;

   always_comb begin
      word_mode = (I_WORD_WIDTH_SELECT == LISIF_WIDTH_WORD);
      // strobes only count at rising link edges
      bnd_rise = cap.rise & cap.bnd & ~bnd_q;
      aux_rise = cap.rise & cap.aux & ~aux_q;
      wr_src_rise = (I_WR_PTR_SOURCE[LISIF_SRC_BND_BIT] & bnd_rise) |
                    (I_WR_PTR_SOURCE[LISIF_SRC_AUX_BIT] & aux_rise);
      rd_src_rise = (I_RD_PTR_SOURCE[LISIF_SRC_BND_BIT] & bnd_rise) |
                    (I_RD_PTR_SOURCE[LISIF_SRC_AUX_BIT] & aux_rise);
      reg_trig = I_SIF_SYNC & word_mode &
                 ((I_FORMATTER_SOURCE == LISIF_FMT_REG_A) |
                  (I_FORMATTER_SOURCE == LISIF_FMT_REG_B)) &
                 (I_WR_PTR_SOURCE == LISIF_SRC_REG_TRIG) &
                 (I_RD_PTR_SOURCE == LISIF_SRC_REG_TRIG);
      wr_reset = wr_src_rise | reg_trig;
      rd_reset = rd_src_rise | reg_trig;
   end

   ////////////////////////////////////////////////////////////////////////////
   // sample assembly
   logic [1:0] phase;
   logic [15:0] i_word;
   logic [7:0] q_hi;
   logic aligned;
   logic [31:0] sample;
   logic sample_valid;
   logic next_bnd_q;
   logic next_aux_q;
   logic [1:0] next_phase;
   logic [15:0] next_i_word;
   logic [7:0] next_q_hi;
   logic next_aligned;
   logic [31:0] next_sample;
   logic next_sample_valid;
   logic [1:0] slot;
   logic [7:0] lane_byte;

   always_comb begin
      next_bnd_q = cap.rise ? cap.bnd : bnd_q;
      next_aux_q = cap.rise ? cap.aux : aux_q;
      next_phase = phase;
      next_i_word = i_word;
      next_q_hi = q_hi;
      next_aligned = aligned | wr_src_rise;
      next_sample = sample;
      next_sample_valid = 1'b0;
      // the byte taken on the aligning edge opens a sample
      slot = wr_src_rise ? LISIF_SLOT_I_HI : phase;
      lane_byte = cap.data[7:0];
      if (cap.rise | cap.fall) begin
         if (word_mode) begin
            if (slot[0] == 1'b0) begin
               next_i_word = cap.data;
               next_phase = LISIF_SLOT_I_LO;
            end else begin
               next_sample = {i_word, cap.data};
               next_sample_valid = 1'b1;
               next_phase = LISIF_SLOT_I_HI;
            end
         end else begin
            unique case (slot)
               LISIF_SLOT_I_HI: next_i_word = {lane_byte, i_word[7:0]};
               LISIF_SLOT_I_LO: next_i_word = {i_word[15:8], lane_byte};
               LISIF_SLOT_Q_HI: next_q_hi = lane_byte;
               LISIF_SLOT_Q_LO: begin
                  next_sample = {i_word, q_hi, lane_byte};
                  next_sample_valid = 1'b1;
               end
            endcase
            next_phase = slot + LISIF_SLOT_I_LO;
         end
      end
   end

   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         bnd_q <= 1'b0;
         aux_q <= 1'b0;
         phase <= LISIF_SLOT_I_HI;
         i_word <= 16'h0000;
         q_hi <= 8'h00;
         aligned <= 1'b0;
         sample <= 32'h00000000;
         sample_valid <= 1'b0;
      end else begin
         bnd_q <= next_bnd_q;
         aux_q <= next_aux_q;
         phase <= next_phase;
         i_word <= next_i_word;
         q_hi <= next_q_hi;
         aligned <= next_aligned;
         sample <= next_sample;
         sample_valid <= next_sample_valid;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // input fifo storage and pointers
   logic [31:0] mem [LISIF_DEPTH];
   logic [2:0] wr_ptr;
   logic [2:0] rd_ptr;
   logic [31:0] rd_data;
   logic rd_valid;
   logic [2:0] next_wr_ptr;
   logic [2:0] next_rd_ptr;
   logic [31:0] next_rd_data;
   logic next_rd_valid;

   always_comb begin
      // a pointer reset outranks the step of the same cycle
      if (wr_reset) begin
         next_wr_ptr = LISIF_WR_PTR_RESET;
      end else if (next_sample_valid) begin
         next_wr_ptr = lisif_inc(wr_ptr);
      end else begin
         next_wr_ptr = wr_ptr;
      end
      if (rd_reset) begin
         next_rd_ptr = LISIF_RD_PTR_RESET;
      end else if (I_READ) begin
         next_rd_ptr = lisif_inc(rd_ptr);
      end else begin
         next_rd_ptr = rd_ptr;
      end
      next_rd_data = I_READ ? mem[rd_ptr] : rd_data;
      next_rd_valid = I_READ;
   end

   // storage has no reset; unread words are simply stale
   always_ff @(posedge I_MCLK) begin
      if (next_sample_valid) begin
         mem[wr_ptr] <= next_sample;
      end
   end

   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         wr_ptr <= LISIF_WR_PTR_RESET;
         rd_ptr <= LISIF_RD_PTR_RESET;
         rd_data <= 32'h00000000;
         rd_valid <= 1'b0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         rd_data <= next_rd_data;
         rd_valid <= next_rd_valid;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // block parity from boundary strobe at the falling edge after its rise
   logic par_armed;
   logic parity;
   logic parity_valid;
   logic next_par_armed;
   logic next_parity;
   logic next_parity_valid;

   always_comb begin
      next_par_armed = par_armed;
      next_parity = parity;
      next_parity_valid = 1'b0;
      if (!I_PARITY_ENABLE) begin
         next_par_armed = 1'b0;
      end else if (bnd_rise) begin
         next_par_armed = 1'b1;
      end else if (cap.fall & par_armed) begin
         next_parity = cap.bnd;
         next_parity_valid = 1'b1;
         next_par_armed = 1'b0;
      end
   end

   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         par_armed <= 1'b0;
         parity <= 1'b0;
         parity_valid <= 1'b0;
      end else begin
         par_armed <= next_par_armed;
         parity <= next_parity;
         parity_valid <= next_parity_valid;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign O_SAMPLE = sample;
   assign O_SAMPLE_VALID = sample_valid;
   assign O_WR_PTR = wr_ptr;
   assign O_RD_PTR = rd_ptr;
   assign O_READ_DATA = rd_data;
   assign O_READ_VALID = rd_valid;
   assign O_ALIGNED = aligned;
   assign O_BLOCK_PARITY = parity;
   assign O_PARITY_VALID = parity_valid;
endmodule // lisif_top
`default_nettype wire

/* File: tb/lisif_chk.sv */
/*
 lisif_chk: port-level assertions for the formatter top.
 Assumes: bound to lisif_top; link idle while pointers are poked by pulses.
*/
`timescale 1ns/1ns
`default_nettype none
module lisif_chk (
   // system
   input wire logic I_MCLK,
   input wire logic I_RST_N,
   // configuration
   input wire logic I_WORD_WIDTH_SELECT,
   input wire logic I_PARITY_ENABLE,
   input wire logic [3:0] I_WR_PTR_SOURCE,
   input wire logic [3:0] I_RD_PTR_SOURCE,
   input wire logic [1:0] I_FORMATTER_SOURCE,
   input wire logic I_SIF_SYNC,
   input wire logic I_READ,
   // outputs
   input wire logic [31:0] O_SAMPLE,
   input wire logic O_SAMPLE_VALID,
   input wire logic [2:0] O_WR_PTR,
   input wire logic [2:0] O_RD_PTR,
   input wire logic O_ALIGNED,
   input wire logic O_PARITY_VALID,
   input wire logic O_READ_VALID
);
   default clocking dcb @(posedge I_MCLK);
   endclocking
   default disable iff (!I_RST_N);
   ////////////////////////////////////////////////////////////////////////
   a_sample_pulse: assert property (O_SAMPLE_VALID |=> !O_SAMPLE_VALID)
      else $error("sample valid longer than one cycle");
   a_sample_hold: assert property ($changed(O_SAMPLE) |-> O_SAMPLE_VALID)
      else $error("sample changed without valid");
   a_wr_step: assert property (O_SAMPLE_VALID |-> O_WR_PTR == $past(O_WR_PTR) + 3'h1)
      else $error("write pointer did not step with sample");
   a_rd_step: assert property (I_READ |=>
      O_READ_VALID && O_RD_PTR == $past(O_RD_PTR) + 3'h1)
      else $error("read did not step pointer");
   a_reg_trig: assert property (I_SIF_SYNC && I_WORD_WIDTH_SELECT &&
      I_FORMATTER_SOURCE[1] && I_WR_PTR_SOURCE == 4'h8 && I_RD_PTR_SOURCE == 4'h8
      |=> O_WR_PTR == 3'h0 && O_RD_PTR == 3'h4)
      else $error("register trigger missed");
   a_reg_refuse: assert property (I_SIF_SYNC && !I_WORD_WIDTH_SELECT && !I_READ
      |=> $stable(O_RD_PTR))
      else $error("register trigger acted in byte mode");
   a_aligned_hold: assert property (O_ALIGNED |=> O_ALIGNED)
      else $error("aligned flag dropped");
   a_parity_off: assert property (!I_PARITY_ENABLE [*4] |-> !O_PARITY_VALID)
      else $error("parity sampled while disabled");
   a_parity_pulse: assert property (O_PARITY_VALID |=> !O_PARITY_VALID)
      else $error("parity valid longer than one cycle");
   c_byte_sample: cover property (O_SAMPLE_VALID && !I_WORD_WIDTH_SELECT);
   c_parity: cover property (O_PARITY_VALID);
   c_trig: cover property (I_SIF_SYNC && I_WORD_WIDTH_SELECT);
endmodule // lisif_chk
`default_nettype wire

/* File: tb/lisif_src_model.sv */
/*
 lisif_src_model: far-side sample source driving link clock, lanes and strobes.
 Assumes: the bench steps it with half and idle; it runs off the system clock.
*/
`timescale 1ns/1ns
`default_nettype none
module lisif_src_model (
   // system
   input wire logic i_clk,
   // link pins
   output logic o_clk,
   output logic [15:0] o_data,
   output logic o_bnd,
   output logic o_aux
);
   initial begin
      o_clk = 1'b0;
      o_data = 16'h0000;
      o_bnd = 1'b0;
      o_aux = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // lanes change mid-half so they stand still around each link edge
   task automatic half(input logic [15:0] d, input logic b, input logic a);
      repeat (2) @(posedge i_clk);
      o_data <= d;
      o_bnd <= b;
      o_aux <= a;
      repeat (2) @(posedge i_clk);
      o_clk <= ~o_clk;
   endtask
   // released lines show the inverse; clock stands low between frames
   task automatic idle();
      repeat (2) @(posedge i_clk);
      o_data <= ~o_data;
      o_bnd <= ~o_bnd;
      o_aux <= ~o_aux;
   endtask
endmodule // lisif_src_model
`default_nettype wire

/* File: tb/testbench.sv */
/*
 testbench: word, byte, parity and register-trigger cases for the formatter.
 Assumes: the source model paces the link at 160 ns; reads follow idle link.
*/
`timescale 1ns/1ns
`default_nettype none
bind lisif_top lisif_chk lisif_chk_inst (.I_MCLK(I_MCLK), .I_RST_N(I_RST_N),
   .I_WORD_WIDTH_SELECT(I_WORD_WIDTH_SELECT), .I_PARITY_ENABLE(I_PARITY_ENABLE),
   .I_WR_PTR_SOURCE(I_WR_PTR_SOURCE), .I_RD_PTR_SOURCE(I_RD_PTR_SOURCE),
   .I_FORMATTER_SOURCE(I_FORMATTER_SOURCE), .I_SIF_SYNC(I_SIF_SYNC), .I_READ(I_READ),
   .O_SAMPLE(O_SAMPLE), .O_SAMPLE_VALID(O_SAMPLE_VALID), .O_WR_PTR(O_WR_PTR),
   .O_RD_PTR(O_RD_PTR), .O_ALIGNED(O_ALIGNED), .O_PARITY_VALID(O_PARITY_VALID),
   .O_READ_VALID(O_READ_VALID));
module testbench
   import lisif_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic wsel = 1'b1;
   logic par_en = 1'b0;
   logic sif = 1'b0;
   logic rd = 1'b0;
   logic [3:0] wr_src = 4'h0;
   logic [3:0] rd_src = 4'h0;
   logic [1:0] fmt = 2'h0;
   logic [31:0] rdata, smp;
   logic rvalid, svalid, aligned, parity, pvalid, lclk, lbnd, laux;
   logic [2:0] wr_ptr, rd_ptr, exp_wr, exp_rd;
   logic [15:0] ldata;
   logic [31:0] samples [$];
   logic par_q [$];
   int fails = 0;
   int n_compared = 0;
   always #10 clk = ~clk;
   always @(posedge clk) begin
      if (svalid === 1'b1) samples.push_back(smp);
      if (pvalid === 1'b1) par_q.push_back(parity);
   end
   lisif_src_model lisif_src_model_inst (.i_clk(clk), .o_clk(lclk), .o_data(ldata),
      .o_bnd(lbnd), .o_aux(laux));
   lisif_top lisif_top_inst (.I_MCLK(clk), .I_RST_N(rst_n), .I_DDR_SOURCE_CLOCK(lclk),
      .I_DATA(ldata), .I_BOUNDARY_STROBE(lbnd), .I_AUX_STROBE(laux),
      .I_WORD_WIDTH_SELECT(wsel), .I_PARITY_ENABLE(par_en), .I_WR_PTR_SOURCE(wr_src),
      .I_RD_PTR_SOURCE(rd_src), .I_FORMATTER_SOURCE(fmt), .I_SIF_SYNC(sif), .I_READ(rd),
      .O_READ_DATA(rdata), .O_READ_VALID(rvalid), .O_SAMPLE(smp), .O_SAMPLE_VALID(svalid),
      .O_WR_PTR(wr_ptr), .O_RD_PTR(rd_ptr), .O_ALIGNED(aligned), .O_BLOCK_PARITY(parity),
      .O_PARITY_VALID(pvalid));
   ////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      if (fails == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         fails++;
      end
   endtask
   // entries are {boundary, aux, lanes}, one per link edge, rising first
   task automatic frame(input logic [17:0] h [6], input int n, input int want);
      for (int i = 0; i < n; i++) lisif_src_model_inst.half(h[i][15:0], h[i][17], h[i][16]);
      lisif_src_model_inst.idle();
      for (int i = 0; i < 300 && samples.size() < want; i++) @(posedge clk);
      if (samples.size() < want) begin
         check("sample count", 32'(want), 32'(samples.size()));
         give_verdict();
      end
      repeat (12) @(posedge clk);
   endtask
   task automatic pulse(input bit is_sif);
      @(posedge clk);
      if (is_sif) sif <= 1'b1;
      else rd <= 1'b1;
      @(posedge clk);
      sif <= 1'b0;
      rd <= 1'b0;
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_word();
      @(posedge clk);
      wr_src <= 4'h1;
      rd_src <= 4'h1;
      pulse(1'b0);
      frame('{18'h11111, 18'h02222, 18'h03333, 18'h04444, 0, 0}, 4, 2);
      check("sample 0", 32'h11112222, samples[0]);
      check("sample 1", 32'h33334444, samples[1]);
      check("wr_ptr", 32'h2, 32'(wr_ptr));
      check("rd_ptr", 32'(LISIF_RD_PTR_RESET), 32'(rd_ptr));
      check("aligned", 32'h1, 32'(aligned));
      repeat (4) pulse(1'b0);
      pulse(1'b0);
      check("read data", 32'h11112222, rdata);
      check("read valid", 32'h1, 32'(rvalid));
      exp_rd = 3'h1;
   endtask
   task automatic t_byte();
      @(posedge clk);
      samples.delete();
      wsel <= 1'b0;
      wr_src <= 4'h2;
      rd_src <= 4'h2;
      frame('{18'h0A511, 18'h05A22, 18'h2A512, 18'h25A34, 18'h0A556, 18'h05A78}, 6, 1);
      check("samples", 32'h1, 32'(samples.size()));
      check("sample", 32'h12345678, samples[0]);
      check("wr_ptr", 32'h1, 32'(wr_ptr));
      check("rd_ptr", 32'(LISIF_RD_PTR_RESET), 32'(rd_ptr));
      check("parity count", 32'h0, 32'(par_q.size()));
      exp_rd = LISIF_RD_PTR_RESET;
   endtask
   task automatic t_parity();
      @(posedge clk);
      samples.delete();
      wsel <= 1'b1;
      par_en <= 1'b1;
      frame('{18'h2AAAA, 18'h0BBBB, 18'h0CCCC, 18'h0DDDD, 18'h2EEEE, 18'h2FFFF}, 6, 3);
      check("parity count", 32'h2, 32'(par_q.size()));
      check("parity 0", 32'h0, 32'(par_q[0]));
      check("parity 1", 32'h1, 32'(par_q[1]));
      check("sample 0", 32'hAAAABBBB, samples[0]);
      check("sample 2", 32'hEEEEFFFF, samples[2]);
      check("wr_ptr", 32'h1, 32'(wr_ptr));
      exp_wr = 3'h1;
      par_en <= 1'b0;
   endtask
   // refusals first, then both formatter values that allow the trigger
   task automatic t_trig();
      logic [2:0] cases [4] = '{3'h5, 3'h2, 3'h6, 3'h7};
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         {wsel, fmt} <= cases[i];
         wr_src <= LISIF_SRC_REG_TRIG;
         rd_src <= LISIF_SRC_REG_TRIG;
         pulse(1'b0);
         exp_rd = exp_rd + 3'h1;
         pulse(1'b1);
         @(posedge clk);
         #1;
         if (cases[i][2] && cases[i][1]) begin
            exp_wr = LISIF_WR_PTR_RESET;
            exp_rd = LISIF_RD_PTR_RESET;
         end
         check("wr_ptr", 32'(exp_wr), 32'(wr_ptr));
         check("rd_ptr", 32'(exp_rd), 32'(rd_ptr));
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      check("wr_ptr", 32'(LISIF_WR_PTR_RESET), 32'(wr_ptr));
      check("rd_ptr", 32'(LISIF_RD_PTR_RESET), 32'(rd_ptr));
      check("aligned", 32'h0, 32'(aligned));
      t_word();
      t_byte();
      t_parity();
      t_trig();
      give_verdict();
   end
endmodule // testbench
`default_nettype wire
